// ===== cw_can_bus_model.sv
`timescale 1ns/1ps

// Wired-AND bus: any dominant party wins, idle bus reads recessive
module cw_can_bus_model (
    input  wire logic node_dom,
    input  wire logic bus_drive_dominant,
    output logic      bus_rx_level
);
    assign bus_rx_level = !(node_dom || bus_drive_dominant);
endmodule // cw_can_bus_model

// ===== cw_can_wake_ctrl.sv
`timescale 1ns/1ps

// Notes on behaviour
// [RULE_01] Wake mode selectable in Stop/Sleep/Restart/Normal; forced in Fail-Safe.
// [RULE_02] Wake pattern: two long dominant phases split by a short recessive gap.
// [RULE_03] Bus wake pulls receive output low until mode changes.
// [RULE_04] Mode field keeps reading wake-capable code 01 after a wake.
// [RULE_05] Programming another mode then wake mode again re-arms detection.
// [RULE_06] Power mode change to Stop, Sleep or Fail-Safe re-arms detection.
// [RULE_07] Clearing the wake status bit is not needed to re-arm.
// [RULE_08] Host powers transceiver supply before Normal; off during wake mode.
// [RULE_09] Wake in Stop/Normal: interrupt low, status set, receive low, mode kept.
// [RULE_10] No automatic Stop to Normal transition; host commands it.
// [RULE_11] Wake in Stop enables a disabled watchdog when configured to.
// [RULE_12] Wake in Sleep/Restart/Fail-Safe goes to Restart, supply ramps, then Normal.
// [RULE_13] Wake leaving Sleep/Restart/Fail-Safe keeps interrupt high.
// [RULE_14] Host reads wake source status after seeing receive output low.
// [RULE_15] Long transmit dominant in Normal: driver off, receive-only, fail flag set.
// [RULE_16] Driver returns when transmit goes recessive; mode bits untouched.
// [RULE_17] Long bus dominant in any mode sets fail flag, mode untouched.
// [RULE_18] Supply undervoltage checked in Normal only: flag set, driver off.
// [RULE_19] Supply recovery resumes Normal operation without mode change.
// [RULE_20] Off mode, the reset default, ignores bus wake activity.
// [RULE_21] Receive-only keeps driver off but forwards bus level.
// [RULE_22] Host keeps transmit recessive until the enabling time has passed.
// [RULE_23] Filter times and time-outs are oscillator counters with parameter limits.
module cw_can_wake_ctrl #(
    parameter int TX_TO_CYC  = cw_pkg::TX_TO_CYC,
    parameter int BUS_TO_CYC = cw_pkg::BUS_TO_CYC
) (
    input  wire logic                      ref_clk,
    input  wire logic                      nrst,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [cw_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      bus_transmit_in,
    input  wire logic                      bus_rx_level,
    input  wire logic                      transceiver_supply_ok,
    input  wire logic                      fail_safe_req,
    output logic                           rx_out,
    output logic                           int_n,
    output logic                           bus_drive_dominant,
    output logic                           main_supply_en,
    output logic                           watchdog_en,
    output cw_pkg::cw_pwr_t                power_mode
);

    function automatic logic hit(input logic [cw_pkg::ADDR_W-1:0] a,
                                 input logic [cw_pkg::ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    logic                rst_meta_ff;
    logic                rst_n_ff;
    logic [1:0]          mode_ff;
    logic [1:0]          nxt_mode;
    cw_pkg::cw_pwr_t     pwr_ff;
    cw_pkg::cw_pwr_t     nxt_pwr;
    cw_pkg::cw_wk_t      wk_ff;
    cw_pkg::cw_wk_t      nxt_wk;
    cw_pkg::cw_status_t  st;
    logic                armed_ff;
    logic                wake_hold_ff;
    logic                bus_wake_ff;
    logic                can_fail_ff;
    logic                supply_low_ff;
    logic                uv_ff;
    logic                tx_to_ff;
    logic                int_n_ff;
    logic                wd_en_ff;
    logic                wd_on_wk_ff;
    logic                rx_ff;
    logic                drv_ff;
    logic                supply_ff;
    logic                pready_ff;
    logic                pslverr_ff;
    logic [31:0]         prdata_ff;
    logic                wr_stb;
    logic                wr_ctrl;
    logic                wr_cfg;
    logic                wr_stat;
    logic                wake_det;
    logic                wk_active;
    logic                bus_dom;
    logic                dom_over;
    logic                gap_over;
    logic                tx_over;
    logic                bus_over;
    logic                ramp_over;
    logic                rearm_pwr;
    logic                driver_on;
    logic [2:0]          req_pwr;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // APB: zero wait states, pready raised in the first access cycle
    assign wr_stb  = psel && penable && pready_ff && pwrite;
    assign wr_ctrl = wr_stb && hit(paddr, cw_pkg::OFF_CTRL);
    assign wr_cfg  = wr_stb && hit(paddr, cw_pkg::OFF_CFG);
    assign wr_stat = wr_stb && hit(paddr, cw_pkg::OFF_STATUS);
    assign req_pwr = pwdata[cw_pkg::PWR_LSB +: 3];

    assign st = '{armed: armed_ff, uv_live: uv_ff, tx_to_live: tx_to_ff,
                  supply_low: supply_low_ff, can_fail: can_fail_ff,
                  bus_wake: bus_wake_ff};

    always_ff @(posedge ref_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end
        else
        begin
            pready_ff  <= psel && !penable;
            pslverr_ff <= psel && !penable && !(hit(paddr, cw_pkg::OFF_CTRL)
                          || hit(paddr, cw_pkg::OFF_CFG) || hit(paddr, cw_pkg::OFF_STATUS));
            if (psel && !penable)
            begin
                prdata_ff <= 32'h0;
                if (hit(paddr, cw_pkg::OFF_CTRL))
                    prdata_ff <= {27'h0, pwr_ff, mode_ff}; // [RULE_04]
                else if (hit(paddr, cw_pkg::OFF_CFG))
                    prdata_ff <= {30'h0, wd_on_wk_ff, wd_en_ff};
                else if (hit(paddr, cw_pkg::OFF_STATUS))
                    prdata_ff <= {26'h0, st}; // [RULE_14]
            end
        end
    end

    // Transceiver mode: only the host changes it, except the Fail-Safe force
    always_comb
    begin
        nxt_mode = mode_ff;
        if (pwr_ff == cw_pkg::PWR_FAILSAFE || nxt_pwr == cw_pkg::PWR_FAILSAFE)
            nxt_mode = cw_pkg::MODE_WAKE; // [RULE_01]
        else if (wr_ctrl)
        begin
            case (pwdata[cw_pkg::MODE_LSB +: 2])
                cw_pkg::MODE_NORMAL,
                cw_pkg::MODE_RXONLY:
                    if (pwr_ff == cw_pkg::PWR_NORMAL || pwr_ff == cw_pkg::PWR_STOP)
                        nxt_mode = pwdata[cw_pkg::MODE_LSB +: 2];
                default:
                    nxt_mode = pwdata[cw_pkg::MODE_LSB +: 2]; // [RULE_01]
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            mode_ff <= cw_pkg::RST_MODE; // [RULE_20]
        else
            mode_ff <= nxt_mode; // [RULE_15] [RULE_17] [RULE_19]
    end

    // Chip power mode
    always_comb
    begin
        nxt_pwr = pwr_ff;
        if (fail_safe_req)
            nxt_pwr = cw_pkg::PWR_FAILSAFE;
        else if (wake_det && (pwr_ff == cw_pkg::PWR_SLEEP || pwr_ff == cw_pkg::PWR_RESTART
                 || pwr_ff == cw_pkg::PWR_FAILSAFE))
            nxt_pwr = cw_pkg::PWR_RESTART; // [RULE_12]
        else if (pwr_ff == cw_pkg::PWR_RESTART && ramp_over)
            nxt_pwr = cw_pkg::PWR_NORMAL; // [RULE_12]
        else if (wr_ctrl && (pwr_ff == cw_pkg::PWR_NORMAL || pwr_ff == cw_pkg::PWR_STOP))
        begin
            case (req_pwr)
                cw_pkg::PWR_NORMAL,
                cw_pkg::PWR_STOP,
                cw_pkg::PWR_SLEEP:
                    nxt_pwr = cw_pkg::cw_pwr_t'(req_pwr); // [RULE_10]
                default:
                    nxt_pwr = pwr_ff;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            pwr_ff <= cw_pkg::RST_PWR;
        else
            pwr_ff <= nxt_pwr;
    end

    assign rearm_pwr = (nxt_pwr != pwr_ff) && (nxt_pwr == cw_pkg::PWR_STOP
                       || nxt_pwr == cw_pkg::PWR_SLEEP || nxt_pwr == cw_pkg::PWR_FAILSAFE);

    // Arming: any non-wake mode prepares the next wake-mode entry
    always_ff @(posedge ref_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            armed_ff <= 1'b1;
        else if (mode_ff != cw_pkg::MODE_WAKE || rearm_pwr)
            armed_ff <= 1'b1; // [RULE_05] [RULE_06] [RULE_07]
        else if (wake_det)
            armed_ff <= 1'b0;
    end

    // Wake pattern detector
    assign bus_dom   = !bus_rx_level;
    assign wk_active = (mode_ff == cw_pkg::MODE_WAKE) && armed_ff; // [RULE_20]

    cw_dur_cnt #(
        .LIMIT (cw_pkg::CNT_W'(cw_pkg::WAKE_DOM_CYC))
    ) u_dom_cnt (
        .clk   (ref_clk),
        .rst_n (rst_n_ff),
        .run   (bus_dom && (wk_ff == cw_pkg::WK_DOM1 || wk_ff == cw_pkg::WK_DOM2)),
        .over  (dom_over)
    ); // [RULE_23]

    cw_dur_cnt #(
        .LIMIT (cw_pkg::CNT_W'(cw_pkg::WAKE_GAP_CYC - 1))
    ) u_gap_cnt (
        .clk   (ref_clk),
        .rst_n (rst_n_ff),
        .run   (!bus_dom && wk_ff == cw_pkg::WK_GAP),
        .over  (gap_over)
    ); // [RULE_23]

    always_comb
    begin
        nxt_wk   = wk_ff;
        wake_det = 1'b0;
        case (wk_ff)
            cw_pkg::WK_IDLE:
                if (bus_dom)
                    nxt_wk = cw_pkg::WK_DOM1;
            cw_pkg::WK_DOM1:
                if (!bus_dom)
                    nxt_wk = dom_over ? cw_pkg::WK_GAP : cw_pkg::WK_IDLE; // [RULE_02]
            cw_pkg::WK_GAP:
                if (bus_dom)
                    nxt_wk = cw_pkg::WK_DOM2;
                else if (gap_over)
                    nxt_wk = cw_pkg::WK_IDLE; // [RULE_02]
            cw_pkg::WK_DOM2:
                if (dom_over)
                begin
                    nxt_wk   = cw_pkg::WK_IDLE;
                    wake_det = 1'b1; // [RULE_02]
                end
                else if (!bus_dom)
                    nxt_wk = cw_pkg::WK_IDLE;
            default:
                nxt_wk = cw_pkg::WK_IDLE;
        endcase
        if (!wk_active)
        begin
            nxt_wk   = cw_pkg::WK_IDLE;
            wake_det = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            wk_ff <= cw_pkg::WK_IDLE;
        else
            wk_ff <= nxt_wk;
    end

    // Receive output hold, released only by a mode change
    always_ff @(posedge ref_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            wake_hold_ff <= 1'b0;
        else if (wake_det)
            wake_hold_ff <= 1'b1; // [RULE_03]
        else if (mode_ff != cw_pkg::MODE_WAKE)
            wake_hold_ff <= 1'b0;
    end

    // Sticky flags: a set in the clearing cycle wins
    always_ff @(posedge ref_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            bus_wake_ff   <= 1'b0;
            can_fail_ff   <= 1'b0;
            supply_low_ff <= 1'b0;
            int_n_ff      <= 1'b1;
        end
        else
        begin
            if (wake_det)
                bus_wake_ff <= 1'b1; // [RULE_09]
            else if (wr_stat && pwdata[cw_pkg::ST_BUS_WAKE])
                bus_wake_ff <= 1'b0;
            if ((tx_over && mode_ff == cw_pkg::MODE_NORMAL) || bus_over)
                can_fail_ff <= 1'b1; // [RULE_15] [RULE_17]
            else if (wr_stat && pwdata[cw_pkg::ST_CAN_FAIL])
                can_fail_ff <= 1'b0;
            if (mode_ff == cw_pkg::MODE_NORMAL && !transceiver_supply_ok)
                supply_low_ff <= 1'b1; // [RULE_18]
            else if (wr_stat && pwdata[cw_pkg::ST_SUPPLY_LOW])
                supply_low_ff <= 1'b0;
            if (wake_det && (pwr_ff == cw_pkg::PWR_NORMAL || pwr_ff == cw_pkg::PWR_STOP))
                int_n_ff <= 1'b0; // [RULE_09] [RULE_13]
            else if (wr_stat && pwdata[cw_pkg::ST_BUS_WAKE])
                int_n_ff <= 1'b1;
        end
    end

    // Watchdog enable; the bus-wake set beats a software disable
    always_ff @(posedge ref_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            wd_en_ff    <= cw_pkg::RST_CFG[cw_pkg::CFG_WD_EN];
            wd_on_wk_ff <= cw_pkg::RST_CFG[cw_pkg::CFG_WD_ON_WK];
        end
        else
        begin
            if (wr_cfg)
                wd_on_wk_ff <= pwdata[cw_pkg::CFG_WD_ON_WK];
            if (wake_det && pwr_ff == cw_pkg::PWR_STOP && !wd_en_ff && wd_on_wk_ff)
                wd_en_ff <= 1'b1; // [RULE_11]
            else if (wr_cfg)
                wd_en_ff <= pwdata[cw_pkg::CFG_WD_EN];
        end
    end

    // Transmit and bus dominant supervision
    cw_dur_cnt #(
        .LIMIT (cw_pkg::CNT_W'(TX_TO_CYC))
    ) u_tx_cnt (
        .clk   (ref_clk),
        .rst_n (rst_n_ff),
        .run   (!bus_transmit_in && mode_ff == cw_pkg::MODE_NORMAL),
        .over  (tx_over)
    ); // [RULE_23]

    cw_dur_cnt #(
        .LIMIT (cw_pkg::CNT_W'(BUS_TO_CYC))
    ) u_bus_cnt (
        .clk   (ref_clk),
        .rst_n (rst_n_ff),
        .run   (bus_dom),
        .over  (bus_over)
    ); // [RULE_17] [RULE_23]

    cw_dur_cnt #(
        .LIMIT (cw_pkg::CNT_W'(cw_pkg::RAMP_CYC))
    ) u_ramp_cnt (
        .clk   (ref_clk),
        .rst_n (rst_n_ff),
        .run   (pwr_ff == cw_pkg::PWR_RESTART),
        .over  (ramp_over)
    );

    always_ff @(posedge ref_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            tx_to_ff <= 1'b0;
            uv_ff    <= 1'b0;
        end
        else
        begin
            if (bus_transmit_in || mode_ff != cw_pkg::MODE_NORMAL)
                tx_to_ff <= 1'b0; // [RULE_16]
            else if (tx_over)
                tx_to_ff <= 1'b1; // [RULE_15]
            // Undervoltage only watched in Normal; recovery is automatic
            uv_ff <= (mode_ff == cw_pkg::MODE_NORMAL) && !transceiver_supply_ok; // [RULE_18] [RULE_19]
        end
    end

    // Driver only in Normal mode with a powered chip and no fault;
    // the host is trusted to respect the enabling time
    assign driver_on = (mode_ff == cw_pkg::MODE_NORMAL) && !tx_to_ff && !uv_ff
                       && (pwr_ff == cw_pkg::PWR_NORMAL || pwr_ff == cw_pkg::PWR_STOP); // [RULE_21] [RULE_22]

    always_ff @(posedge ref_clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            rx_ff     <= 1'b1;
            drv_ff    <= 1'b0;
            supply_ff <= 1'b1;
        end
        else
        begin
            drv_ff    <= driver_on && !bus_transmit_in; // [RULE_15] [RULE_18]
            supply_ff <= (nxt_pwr != cw_pkg::PWR_SLEEP) && (nxt_pwr != cw_pkg::PWR_FAILSAFE); // [RULE_12]
            case (mode_ff)
                cw_pkg::MODE_NORMAL,
                cw_pkg::MODE_RXONLY:
                    rx_ff <= bus_rx_level; // [RULE_21]
                cw_pkg::MODE_WAKE:
                    rx_ff <= !(wake_hold_ff || wake_det); // [RULE_03] [RULE_12]
                default:
                    rx_ff <= 1'b1;
            endcase
        end
    end

    assign prdata             = prdata_ff;
    assign pready             = pready_ff;
    assign pslverr            = pslverr_ff;
    assign rx_out             = rx_ff;
    assign int_n              = int_n_ff; // [RULE_13]
    assign bus_drive_dominant = drv_ff;
    assign main_supply_en     = supply_ff;
    assign watchdog_en        = wd_en_ff;
    assign power_mode         = pwr_ff;

endmodule // cw_can_wake_ctrl

// ===== cw_can_wake_ctrl_chk.sv
`timescale 1ns/1ps

module cw_can_wake_ctrl_chk #(
    parameter int TX_TO_CYC  = 20,
    parameter int BUS_TO_CYC = 20
) (
    input wire logic            ref_clk,
    input wire logic            nrst,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic            pready,
    input wire logic            pslverr,
    input wire logic            bus_transmit_in,
    input wire logic            transceiver_supply_ok,
    input wire logic            fail_safe_req,
    input wire logic            int_n,
    input wire logic            bus_drive_dominant,
    input wire cw_pkg::cw_pwr_t power_mode
);
    logic [7:0] tx_cnt_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // Saturates so a stuck transmit line never wraps to zero
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            tx_cnt_ff <= 8'h00;
        else if (bus_transmit_in)
            tx_cnt_ff <= 8'h00;
        else if (tx_cnt_ff != 8'hFF)
            tx_cnt_ff <= tx_cnt_ff + 8'h01;
    end

    AST_PREADY_NEXT: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("pready not a one-cycle answer");
    AST_SLVERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_INT_ONLY_AWAKE: assert property (
        $fell(int_n) |-> $past(power_mode) inside {cw_pkg::PWR_NORMAL, cw_pkg::PWR_STOP})
        else $error("interrupt raised outside Normal or Stop");
    AST_STOP_KEPT: assert property (
        power_mode == cw_pkg::PWR_STOP && !(psel && penable && pwrite)
        |=> power_mode != cw_pkg::PWR_NORMAL)
        else $error("Stop left for Normal without host");
    AST_SLEEP_EXIT: assert property (
        power_mode == cw_pkg::PWR_SLEEP && !fail_safe_req && !$past(fail_safe_req)
        |=> power_mode inside {cw_pkg::PWR_SLEEP, cw_pkg::PWR_RESTART})
        else $error("Sleep left to a mode other than Restart");
    AST_DRIVE_NEEDS_TX: assert property (
        bus_drive_dominant |-> !$past(bus_transmit_in))
        else $error("driver dominant without transmit request");
    AST_TX_TIMEOUT: assert property (
        int'(tx_cnt_ff) > TX_TO_CYC + 4 |-> !bus_drive_dominant)
        else $error("driver still on after transmit time-out");
    AST_UV_DRIVE_OFF: assert property (
        !transceiver_supply_ok [*3] |-> !bus_drive_dominant)
        else $error("driver on during supply undervoltage");
endmodule // cw_can_wake_ctrl_chk

// ===== cw_dur_cnt.sv
`timescale 1ns/1ps

module cw_dur_cnt #(
    parameter logic [cw_pkg::CNT_W-1:0] LIMIT = 20'h00001
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic run,
    output logic      over
);

    logic [cw_pkg::CNT_W-1:0] cnt_ff;

    // Saturates one above the limit so a long level never wraps
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_ff <= '0;
        else if (!run)
            cnt_ff <= '0;
        else if (cnt_ff <= LIMIT)
            cnt_ff <= cnt_ff + 1'b1;
    end

    assign over = (cnt_ff > LIMIT);

endmodule // cw_dur_cnt

// ===== cw_pkg.sv
package cw_pkg;

    // Transceiver mode codes; wake-capable is fixed at 01
    localparam logic [1:0] MODE_OFF    = 2'h0;
    localparam logic [1:0] MODE_WAKE   = 2'h1;
    localparam logic [1:0] MODE_RXONLY = 2'h2;
    localparam logic [1:0] MODE_NORMAL = 2'h3;

    // Chip power modes, Gray along Normal-Stop-Sleep-Restart-Fail-Safe
    typedef enum logic [2:0] {
        PWR_NORMAL   = 3'h0,
        PWR_STOP     = 3'h1,
        PWR_SLEEP    = 3'h3,
        PWR_RESTART  = 3'h2,
        PWR_FAILSAFE = 3'h6
    } cw_pwr_t;

    // Wake pattern detector states, Gray along the pattern
    typedef enum logic [1:0] {
        WK_IDLE = 2'h0,
        WK_DOM1 = 2'h1,
        WK_GAP  = 2'h3,
        WK_DOM2 = 2'h2
    } cw_wk_t;

    typedef struct packed {
        logic armed;
        logic uv_live;
        logic tx_to_live;
        logic supply_low;
        logic can_fail;
        logic bus_wake;
    } cw_status_t;

    // APB map
    localparam int          ADDR_W     = 8;
    localparam logic [7:0]  OFF_CTRL   = 8'h00;
    localparam logic [7:0]  OFF_CFG    = 8'h04;
    localparam logic [7:0]  OFF_STATUS = 8'h08;

    // CTRL fields
    localparam int MODE_LSB = 0;
    localparam int PWR_LSB  = 2;
    // CFG fields
    localparam int CFG_WD_EN     = 0;
    localparam int CFG_WD_ON_WK  = 1;
    // STATUS fields (low three are write-one-to-clear)
    localparam int ST_BUS_WAKE   = 0;
    localparam int ST_CAN_FAIL   = 1;
    localparam int ST_SUPPLY_LOW = 2;

    localparam logic [1:0]  RST_MODE = MODE_OFF;
    localparam cw_pwr_t     RST_PWR  = PWR_NORMAL;
    localparam logic [1:0]  RST_CFG  = 2'h0;

    // Timing
    localparam int CLK_PERIOD_NS      = 100;
    localparam int CNT_W              = 20;
    localparam int WAKE_DOM_TIME_NS   = 500;
    localparam int WAKE_GAP_TIME_NS   = 1000;
    localparam int TX_TIMEOUT_US      = 1000;
    localparam int BUS_TIMEOUT_US     = 1000;
    localparam int RAMP_TIME_US       = 100;

    // Least times round up, longest round down, never below one cycle
    localparam int WAKE_DOM_CYC = (WAKE_DOM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_GAP_CYC_R = WAKE_GAP_TIME_NS / CLK_PERIOD_NS;
    localparam int WAKE_GAP_CYC = (WAKE_GAP_CYC_R < 1) ? 1 : WAKE_GAP_CYC_R;
    localparam int TX_TO_CYC    = (TX_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUS_TO_CYC   = (BUS_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAMP_CYC     = (RAMP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ===== test_cw_can_wake_ctrl.sv
`timescale 1ns/1ps

module test_cw_can_wake_ctrl;
    localparam int         TO = 20;
    localparam logic [7:0] CT = cw_pkg::OFF_CTRL;
    localparam logic [7:0] CF = cw_pkg::OFF_CFG;
    localparam logic [7:0] ST = cw_pkg::OFF_STATUS;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] q;
        logic        e;
    } cw_row_t;
    localparam cw_row_t ROWS [7] = '{
        '{1'b0, ST, 32'h0, 32'h20, 1'b0}, '{1'b1, CF, 32'h2, 32'h0, 1'b0},
        '{1'b0, CF, 32'h0, 32'h2, 1'b0}, '{1'b0, 8'h0C, 32'h0, 32'h0, 1'b1},
        '{1'b1, 8'h0C, 32'h3, 32'h0, 1'b1}, '{1'b1, CT, 32'h3, 32'h0, 1'b0},
        '{1'b0, CT, 32'h0, 32'h3, 1'b0}};

    logic            ref_clk = 1'b0;
    logic            nrst = 1'b0;
    logic            psel = 1'b0;
    logic            penable = 1'b0;
    logic            pwrite = 1'b0;
    logic [7:0]      paddr = 8'h00;
    logic [31:0]     pwdata = 32'h0;
    logic            tx_in = 1'b1;
    logic            sup_ok = 1'b1;
    logic            fs_req = 1'b0;
    logic            node_dom = 1'b0;
    logic [31:0]     prdata, rd;
    logic            pready, pslverr, er, rx_lvl, rx_out, int_n, drv, ms_en, wd_en;
    cw_pkg::cw_pwr_t pmode;
    int              n_errors = 0;
    int              checks_done = 0;

    always #50 ref_clk = ~ref_clk;

    cw_can_bus_model i_bus (.node_dom(node_dom), .bus_drive_dominant(drv),
        .bus_rx_level(rx_lvl));
    cw_can_wake_ctrl #(.TX_TO_CYC(TO), .BUS_TO_CYC(TO)) i_dut (.ref_clk(ref_clk),
        .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bus_transmit_in(tx_in), .bus_rx_level(rx_lvl), .transceiver_supply_ok(sup_ok),
        .fail_safe_req(fs_req), .rx_out(rx_out), .int_n(int_n),
        .bus_drive_dominant(drv), .main_supply_en(ms_en), .watchdog_en(wd_en),
        .power_mode(pmode));

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wup(input int d);
        node_dom <= 1'b1;
        repeat (d) @(posedge ref_clk);
        node_dom <= 1'b0;
        repeat (5) @(posedge ref_clk);
        node_dom <= 1'b1;
        repeat (d) @(posedge ref_clk);
        node_dom <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic print_verdict;
        $display("errors=%0d checks=%0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        cyc(5);
        nrst <= 1'b1;
        cyc(3);
        chk1(rx_out, 1'b1);
        wup(8);
        chk1(rx_out, 1'b1);
        foreach (ROWS[i])
        begin
            apb(ROWS[i].w, ROWS[i].a, ROWS[i].d);
            if (!ROWS[i].w) chk32(rd, ROWS[i].q);
            chk1(er, ROWS[i].e);
        end
        // Transmit held recessive until Normal mode was set
        tx_in <= 1'b0;
        cyc(3);
        chk1(drv, 1'b1);
        cyc(TO + 5);
        chk1(drv, 1'b0);
        tx_in <= 1'b1;
        cyc(3);
        tx_in <= 1'b0;
        cyc(3);
        chk1(drv, 1'b1);
        sup_ok <= 1'b0;
        cyc(4);
        chk1(drv, 1'b0);
        sup_ok <= 1'b1;
        cyc(4);
        chk1(drv, 1'b1);
        tx_in <= 1'b1;
        apb(1'b0, ST, 32'h0);
        chk32(rd[2:0], 32'h6);
        apb(1'b0, CT, 32'h0);
        chk32(rd, 32'h3);
        apb(1'b1, ST, 32'h6);
        apb(1'b1, CT, 32'h2);
        tx_in <= 1'b0;
        node_dom <= 1'b1;
        cyc(4);
        chk1(drv, 1'b0);
        chk1(rx_out, 1'b0);
        tx_in <= 1'b1;
        cyc(TO + 5);
        node_dom <= 1'b0;
        apb(1'b0, ST, 32'h0);
        chk1(rd[cw_pkg::ST_CAN_FAIL], 1'b1);
        apb(1'b0, CT, 32'h0);
        chk32(rd, 32'h2);
        apb(1'b1, CT, 32'h1);
        sup_ok <= 1'b0;
        wup(4);
        chk1(rx_out, 1'b1);
        wup(8);
        chk1(rx_out, 1'b0);
        chk1(int_n, 1'b0);
        apb(1'b0, CT, 32'h0);
        chk32(rd, 32'h1);
        apb(1'b1, CT, 32'h0);
        apb(1'b1, CT, 32'h1);
        chk1(rx_out, 1'b1);
        apb(1'b0, ST, 32'h0);
        chk32(rd[5:0], 32'h23);
        apb(1'b1, ST, 32'h1);
        apb(1'b1, CT, 32'h5);
        chk1(int_n, 1'b1);
        wup(8);
        chk1(int_n, 1'b0);
        chk1(wd_en, 1'b1);
        cyc(20);
        chk32(32'(pmode), 32'(cw_pkg::PWR_STOP));
        apb(1'b1, ST, 32'h1);
        apb(1'b1, CT, 32'hD);
        apb(1'b0, ST, 32'h0);
        chk1(rd[5], 1'b1);
        wup(8);
        chk32(32'(pmode), 32'(cw_pkg::PWR_RESTART));
        chk1(int_n, 1'b1);
        cyc(cw_pkg::RAMP_CYC + 20);
        chk32(32'(pmode), 32'(cw_pkg::PWR_NORMAL));
        chk1(ms_en, 1'b1);
        chk1(rx_out, 1'b0);
        fs_req <= 1'b1;
        cyc(2);
        fs_req <= 1'b0;
        cyc(3);
        chk32(32'(pmode), 32'(cw_pkg::PWR_FAILSAFE));
        apb(1'b0, CT, 32'h0);
        chk32(rd[1:0], 32'h1);
        wup(8);
        chk32(32'(pmode), 32'(cw_pkg::PWR_RESTART));
        chk1(int_n, 1'b1);
        print_verdict();
    end

    initial
    begin
        cyc(20000);
        n_errors++;
        print_verdict();
    end
endmodule // test_cw_can_wake_ctrl

bind cw_can_wake_ctrl cw_can_wake_ctrl_chk #(.TX_TO_CYC(TX_TO_CYC), .BUS_TO_CYC(BUS_TO_CYC))
    i_chk (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .bus_transmit_in(bus_transmit_in), .transceiver_supply_ok(transceiver_supply_ok),
    .fail_safe_req(fail_safe_req), .int_n(int_n),
    .bus_drive_dominant(bus_drive_dominant), .power_mode(power_mode));
